// file: dv/smf_top_sva.sv
// concurrent checks on the ports of the memory partition and queue control block
`timescale 1ns/1ps
`default_nettype none
module smf_top_sva
  import smf_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic [13:0]          avs_address,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic                 avs_waitrequest,
  input wire logic                 data_push_valid,
  input wire logic                 data_push_ready,
  input wire logic [TRIGGER_W-1:0] launch_program,
  input wire logic [TRIGGER_W-1:0] launch_accept,
  input wire logic [3:0][10:0]     program_base,
  input wire logic [3:0][10:0]     program_length,
  input wire logic [2:0]           data_queue_mode,
  input wire logic [2:0]           data_queue_size,
  input wire logic [2:0]           command_store_mode,
  input wire logic [2:0]           command_store_size,
  input wire logic [SYNC_W-1:0]    sync_out
);
  logic        wr_ok; // a write completes at this edge
  logic [31:0] wd_q;  // write data of the previous edge
  assign wr_ok = avs_write && !avs_waitrequest;
  // keep last write data so fields can be sliced after the edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= 32'h0000_0000;
    end else begin
      wd_q <= avs_writedata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst_val;
    $rose(rst_n) |-> data_queue_mode == 3'h2 && command_store_mode == 3'h2
      && sync_out == 8'h00 && launch_program == 4'h0;
  endproperty
  property p_qmode;
    wr_ok && avs_address == OFS_MEMORY_PARTITION_CTRL && avs_byteenable[1]
      |=> data_queue_mode == wd_q[11:9];
  endproperty
  property p_qsize;
    wr_ok && avs_address == OFS_MEMORY_PARTITION_CTRL && avs_byteenable[1:0] == 2'h3
      |=> data_queue_size == wd_q[8:6];
  endproperty
  property p_cmd;
    wr_ok && avs_address == OFS_MEMORY_PARTITION_CTRL && avs_byteenable[0]
      |=> command_store_mode == wd_q[5:3] && command_store_size == wd_q[2:0];
  endproperty
  property p_desc;
    wr_ok && avs_address == OFS_PROGRAM_ONE_DESC && avs_byteenable == 4'hF
      |=> program_base[1] == wd_q[10:0] && program_length[1] == wd_q[26:16];
  endproperty
  property p_sync;
    wr_ok && avs_address == OFS_EXTERNAL_SYNC_OUTPUTS && avs_byteenable[0]
      |=> sync_out == wd_q[7:0];
  endproperty
  property p_trig_set;
    wr_ok && avs_address == OFS_SEQUENCE_TRIGGER && avs_byteenable[0]
      |=> (launch_program & wd_q[3:0]) == wd_q[3:0];
  endproperty
  property p_launch_program_0_hold;
    launch_program[0] && !launch_accept[0] |=> launch_program[0];
  endproperty
  property p_push_cap;
    data_push_ready |-> data_queue_size inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
  a_qmode: assert property (p_qmode) else $error("queue mode not stored");
  a_qsize: assert property (p_qsize) else $error("queue size not stored");
  a_cmd: assert property (p_cmd) else $error("command fields not stored");
  a_desc: assert property (p_desc) else $error("descriptor not stored");
  a_sync: assert property (p_sync) else $error("sync pins not driven");
  a_trig_set: assert property (p_trig_set) else $error("launch not set");
  a_launch_program_0_hold: assert property (p_launch_program_0_hold) else $error("launch 0 lost");
  a_push_cap: assert property (p_push_cap) else $error("push with no size");
  c_trig: cover property (wr_ok && avs_address == OFS_SEQUENCE_TRIGGER);
  c_push: cover property (data_push_valid && data_push_ready);
  c_accept: cover property ((launch_accept & launch_program) != 4'h0);
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the memory partition and queue control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
  import smf_pkg::*;
;
  logic ref_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, push_v = 0;
  logic [13:0] avs_address = 14'h0000;
  logic [31:0] avs_writedata = 32'h0, push_d = 32'h0, avs_readdata, q, d;
  logic [3:0] avs_byteenable = 4'hF, ben = 4'hF, acc = 4'h0, launch;
  logic avs_waitrequest, push_r, high, irq, ok;
  logic [3:0][10:0] base, len;
  logic [2:0] qmode, qsize, cmode, csize;
  logic [7:0] sync;
  logic [31:0] exp_q[$];
  logic [13:0] rw_tab[7];
  int n_mismatch = 0, cmp_count = 0, seed = 3093, cyc = 0;
  // half period of a 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  smf_top #(.QUEUE_DEPTH(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .data_push_valid(push_v), .data_push_data(push_d), .data_push_ready(push_r),
    .launch_program(launch), .launch_accept(acc), .program_base(base),
    .program_length(len), .data_queue_mode(qmode), .data_queue_size(qsize),
    .command_store_mode(cmode), .command_store_size(csize), .sync_out(sync),
    .queue_high_level(high), .irq(irq));
  // verdict and end of run
  task automatic give_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one avalon access, held until waitrequest is low at an edge
  task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= ben;
    avs_write <= wr;
    avs_read <= !wr;
    // waitrequest and read data are both taken at one rising edge
    do @(posedge ref_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(negedge ref_clk);
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(q, e)
  endtask
  // one queue word, ok tells whether it was taken
  task automatic push(input logic [31:0] w);
    @(posedge ref_clk);
    push_v <= 1;
    push_d <= w;
    @(posedge ref_clk);
    ok = push_r;
    push_v <= 0;
  endtask
  // one cycle pulse on launch_accept
  task automatic accept(input logic [3:0] b);
    @(posedge ref_clk);
    acc <= b;
    @(posedge ref_clk);
    acc <= 4'h0;
    @(negedge ref_clk);
  endtask
  // readback value after write masking of reserved bits
  function automatic logic [31:0] rw_exp(input logic [13:0] a, input logic [31:0] v);
    case (a)
      OFS_DATA_QUEUE_THRESHOLD: return v & 32'h07FF_0000;
      OFS_EXTERNAL_SYNC_OUTPUTS: return v & 32'h0000_00FF;
      OFS_MEMORY_PARTITION_CTRL: return v & 32'h0000_0FFF;
      default: return v & 32'h07FF_07FF;
    endcase
  endfunction
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    rw_tab = '{OFS_PROGRAM_ZERO_DESC, OFS_PROGRAM_ONE_DESC, OFS_PROGRAM_TWO_DESC,
      OFS_PROGRAM_THREE_DESC, OFS_DATA_QUEUE_THRESHOLD, OFS_EXTERNAL_SYNC_OUTPUTS,
      OFS_MEMORY_PARTITION_CTRL};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    // reset values, then random write and readback
    rd_chk(OFS_MEMORY_PARTITION_CTRL, PARTITION_RESET);
    for (int i = 0; i < 6; i++) rd_chk(rw_tab[i], 32'h0);
    rd_chk(OFS_QUEUE_FILL_COUNT, 32'h0);
    rd_chk(14'h0100, 32'h0);
    for (int i = 0; i < 21; i++) begin
      d = $random(seed);
      bus(1, rw_tab[i % 7], d);
      rd_chk(rw_tab[i % 7], rw_exp(rw_tab[i % 7], d));
    end
    // descriptor and sync fields reach their ports
    for (int n = 0; n < 4; n++) begin
      d = $random(seed);
      bus(1, rw_tab[n], d);
      `CHK(base[n], d[10:0])
      `CHK(len[n], d[26:16])
    end
    d = $random(seed);
    bus(1, OFS_EXTERNAL_SYNC_OUTPUTS, d);
    `CHK(sync, d[7:0])
    // both data queue mode codes and the three size codes
    for (int s = 1; s < 4; s++) begin
      for (int m = 2; m < 4; m++) begin
        bus(1, OFS_MEMORY_PARTITION_CTRL, {20'h0, 3'(m), 3'(s), 3'h1, 3'(s)});
        `CHK(qmode, 3'(m))
        `CHK(qsize, 3'(s))
        `CHK({cmode, csize}, {3'h1, 3'(s)})
      end
    end
    bus(1, OFS_MEMORY_PARTITION_CTRL, 32'h0000_0409);
    push(32'h1234_5678);
    `CHK(ok, 1'b0)
    // fifo mode fill past capacity, threshold event and drain
    bus(1, OFS_MEMORY_PARTITION_CTRL, 32'h0000_0449);
    bus(1, OFS_DATA_QUEUE_THRESHOLD, 32'h0004_0000);
    bus(1, OFS_EVENT_MASK, 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      push(d);
      `CHK(ok, 1'(i < 8))
      if (i < 8) exp_q.push_back(d);
    end
    rd_chk(OFS_QUEUE_FILL_COUNT, 32'h0008_0000);
    `CHK({high, irq}, 2'h3)
    for (int i = 0; i < 8; i++) rd_chk(OFS_QUEUE_READ_PORT, exp_q[i]);
    rd_chk(OFS_QUEUE_READ_PORT, 32'h0);
    rd_chk(OFS_QUEUE_FILL_COUNT, 32'h0);
    bus(0, OFS_EVENT_STATUS, 32'h0);
    `CHK(q[EVT_EMPTY_READ], 1'b1)
    @(negedge ref_clk);
    `CHK({high, irq}, 2'h0)
    // stream mode drops the oldest words when full
    bus(1, OFS_MEMORY_PARTITION_CTRL, 32'h0000_0649);
    exp_q.delete();
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      push(d);
      `CHK(ok, 1'b1)
      exp_q.push_back(d);
    end
    for (int i = 2; i < 10; i++) rd_chk(OFS_QUEUE_READ_PORT, exp_q[i]);
    // byte lane 0 only
    ben = 4'h1;
    bus(1, OFS_MEMORY_PARTITION_CTRL, 32'h0000_0FFF);
    ben = 4'hF;
    rd_chk(OFS_MEMORY_PARTITION_CTRL, 32'h0000_06FF);
    // launch bits, accept and write-to-set bit 0
    bus(1, OFS_SEQUENCE_TRIGGER, 32'h0000_000F);
    `CHK(launch, 4'hF)
    accept(4'h2);
    `CHK(launch, 4'hD)
    bus(1, OFS_SEQUENCE_TRIGGER, 32'h0000_0000);
    `CHK(launch, 4'h1)
    accept(4'h1);
    `CHK(launch, 4'h0)
    give_verdict();
  end
endmodule
bind smf_top smf_top_sva chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .data_push_valid(data_push_valid), .data_push_ready(data_push_ready),
  .launch_program(launch_program), .launch_accept(launch_accept),
  .program_base(program_base), .program_length(program_length),
  .data_queue_mode(data_queue_mode), .data_queue_size(data_queue_size),
  .command_store_mode(command_store_mode), .command_store_size(command_store_size),
  .sync_out(sync_out));
`default_nettype wire

// file: logic/smf_event_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module smf_event_irq #(
  parameter int N = 4
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [N-1:0]  event_in,
  input  wire logic          clear_en,
  input  wire logic [N-1:0]  clear_bits,
  input  wire logic          mask_we,
  input  wire logic [N-1:0]  mask_wdata,
  output logic [N-1:0]       status,
  output logic [N-1:0]       mask,
  output logic               irq
);
  // status: a new event wins over the read clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(clear_en ? clear_bits : '0)) | event_in;
    end
  end

  // mask register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (mask_we) begin
      mask <= mask_wdata;
    end
  end

  // level interrupt while any enabled status bit is set
  assign irq = |(status & mask);
endmodule
`default_nettype wire

// file: logic/smf_pkg.sv
// shared constants for the sequencer memory and data queue control block
package smf_pkg;

  // register byte offsets on the avalon slave
  localparam logic [13:0] OFS_SEQUENCE_TRIGGER      = 14'h0430;
  localparam logic [13:0] OFS_EXTERNAL_SYNC_OUTPUTS = 14'h2054;
  localparam logic [13:0] OFS_QUEUE_READ_PORT       = 14'h206C;
  localparam logic [13:0] OFS_PROGRAM_ZERO_DESC     = 14'h21CC;
  localparam logic [13:0] OFS_PROGRAM_TWO_DESC      = 14'h21D0;
  localparam logic [13:0] OFS_MEMORY_PARTITION_CTRL = 14'h21D8;
  localparam logic [13:0] OFS_DATA_QUEUE_THRESHOLD  = 14'h21E0;
  localparam logic [13:0] OFS_PROGRAM_THREE_DESC    = 14'h21E4;
  localparam logic [13:0] OFS_PROGRAM_ONE_DESC      = 14'h21E8;
  localparam logic [13:0] OFS_QUEUE_FILL_COUNT      = 14'h2200;
  localparam logic [13:0] OFS_EVENT_STATUS          = 14'h2210;
  localparam logic [13:0] OFS_EVENT_MASK            = 14'h2214;

  // memory partition control fields
  localparam int DATA_MODE_LSB = 9;
  localparam int DATA_SIZE_LSB = 6;
  localparam int CMD_MODE_LSB  = 3;
  localparam int CMD_SIZE_LSB  = 0;
  localparam logic [31:0] PARTITION_RESET = 32'h0000_0410;

  // shared 11-bit field positions of descriptors, threshold and count
  localparam int HI_FIELD_LSB = 16;
  localparam int LO_FIELD_LSB = 0;
  localparam int FIELD11_W    = 11;

  // trigger and sync widths
  localparam int TRIGGER_W = 4;
  localparam int SYNC_W    = 8;

  // event status bit positions
  localparam int EVT_W          = 4;
  localparam int EVT_HIGH_LEVEL = 0;
  localparam int EVT_DROPPED    = 1;
  localparam int EVT_LAUNCHED   = 2;
  localparam int EVT_EMPTY_READ = 3;

  // data queue mode codes
  typedef enum logic [2:0] {
    SMF_QMODE_FIFO   = 3'b010,
    SMF_QMODE_STREAM = 3'b011
  } smf_qmode_t;

  // size codes shared by both partitions, in words of 32 bits
  localparam logic [2:0]  SIZE_CODE_2K  = 3'b001;
  localparam logic [2:0]  SIZE_CODE_4K  = 3'b010;
  localparam logic [2:0]  SIZE_CODE_6K  = 3'b011;
  localparam logic [10:0] WORDS_2K      = 11'h200;
  localparam logic [10:0] WORDS_4K      = 11'h400;
  localparam logic [10:0] WORDS_6K      = 11'h600;

endpackage

// file: logic/smf_top.sv
// sequencer memory partition, data queue and trigger control with avalon slave
//
// Behaviour
// RULE1: data queue mode bits 11:9, fifo/stream, reset 2
// RULE2: data queue size bits 8:6, 2/4/6 kB; the queue holds at most QUEUE_DEPTH words
// RULE3: command store mode 5:3, size 2:0
// RULE4: threshold bits 26:16 at 0x21E0, rest zero
// RULE5: per program base 10:0, length 26:16
// RULE6: fill count bits 26:16 tracks queue words
// RULE7: eight sync bits drive general purpose outputs
// RULE8: trigger bits 3:0 launch programs, bit0 sets
// RULE9: empty queue read returns zero, no change
// RULE10: flag when count reaches high threshold
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module smf_top
  import smf_pkg::*;
#(
  parameter int QUEUE_DEPTH = 16
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [13:0]            avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // data words from the sequencer into the queue
  input  wire logic                   data_push_valid,
  input  wire logic [31:0]            data_push_data,
  output logic                        data_push_ready,
  // program launch handshake with the sequencer
  output logic [TRIGGER_W-1:0]        launch_program,
  input  wire logic [TRIGGER_W-1:0]   launch_accept,
  output logic [3:0][10:0]            program_base,
  output logic [3:0][10:0]            program_length,
  // partition configuration toward the memory arbiter
  output logic [2:0]                  data_queue_mode,
  output logic [2:0]                  data_queue_size,
  output logic [2:0]                  command_store_mode,
  output logic [2:0]                  command_store_size,
  // sync pins and status
  output logic [SYNC_W-1:0]           sync_out,
  output logic                        queue_high_level,
  output logic                        irq
);

  // merge written bytes into an old register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // words held by a size code, zero for reserved codes
  function automatic logic [10:0] size_words(input logic [2:0] code);
    case (code)
      SIZE_CODE_2K: size_words = WORDS_2K;
      SIZE_CODE_4K: size_words = WORDS_4K;
      SIZE_CODE_6K: size_words = WORDS_6K;
      default:      size_words = 11'h000;
    endcase
  endfunction

  // pack two 11-bit fields into a register image
  function automatic logic [31:0] pack_hi_lo(input logic [10:0] hi,
                                             input logic [10:0] lo);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[HI_FIELD_LSB +: FIELD11_W] = hi;
    r[LO_FIELD_LSB +: FIELD11_W] = lo;
    return r;
  endfunction

  // bus slave state
  typedef enum logic [1:0] {
    SMF_BUS_IDLE = 2'b00,
    SMF_BUS_DONE = 2'b01
  } smf_bus_t;

  smf_bus_t           bus_state;      // idle or answering
  logic [31:0]        read_latch;     // read data captured on the first edge
  logic [31:0]        next_read;      // read mux output
  logic               accept;         // edge at which the access completes
  logic               wr_acc;         // completing write
  logic               rd_acc;         // completing read
  logic [31:0]        wr_merged;      // write data merged over current value
  logic [31:0]        cur_value;      // value now at the addressed register

  logic [31:0]        partition;      // memory partition control
  logic [10:0]        high_thres;     // data queue high threshold
  logic [3:0][10:0]   base_q;         // program bases
  logic [3:0][10:0]   length_q;       // program lengths
  logic [TRIGGER_W-1:0] trigger;      // pending launch bits
  logic [SYNC_W-1:0]  sync_q;         // sync output bits

  logic [31:0]        q_head;         // oldest queue word
  logic [10:0]        q_count;        // words held
  logic               q_dropped;      // stream overwrite pulse
  logic               q_pop;          // read of the queue port
  logic               empty_read;     // read of the port while empty
  logic [EVT_W-1:0]   evt;            // events into the status register
  logic [EVT_W-1:0]   evt_status;     // sticky status
  logic [EVT_W-1:0]   evt_mask;       // interrupt mask
  logic [EVT_W-1:0]   status_snap;    // status seen by the pending read

  // the first edge of a request captures data, the second completes it
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state == SMF_BUS_IDLE);
  assign accept = (avs_read || avs_write) && (bus_state == SMF_BUS_DONE);
  assign wr_acc = accept && avs_write;
  assign rd_acc = accept && avs_read;
  assign wr_merged = merge_bytes(cur_value, avs_writedata, avs_byteenable);
  assign avs_readdata = read_latch;

  // bus handshake state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= SMF_BUS_IDLE;
    end else begin
      case (bus_state)
        SMF_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= SMF_BUS_DONE;
          end
        end
        SMF_BUS_DONE: bus_state <= SMF_BUS_IDLE;
        default:      bus_state <= SMF_BUS_IDLE;
      endcase
    end
  end

  // register read mux; unmapped addresses read zero
  always_comb begin
    next_read = 32'h0000_0000;
    case (avs_address)
      OFS_SEQUENCE_TRIGGER:      next_read = {28'h000_0000, trigger};
      OFS_EXTERNAL_SYNC_OUTPUTS: next_read = {24'h00_0000, sync_q};
      OFS_QUEUE_READ_PORT:       next_read = (q_count != 11'h000) ? q_head
                                                                  : 32'h0000_0000; // see RULE9
      OFS_PROGRAM_ZERO_DESC:     next_read = pack_hi_lo(length_q[0], base_q[0]);
      OFS_PROGRAM_ONE_DESC:      next_read = pack_hi_lo(length_q[1], base_q[1]);
      OFS_PROGRAM_TWO_DESC:      next_read = pack_hi_lo(length_q[2], base_q[2]);
      OFS_PROGRAM_THREE_DESC:    next_read = pack_hi_lo(length_q[3], base_q[3]); // see RULE5
      OFS_MEMORY_PARTITION_CTRL: next_read = partition;
      OFS_DATA_QUEUE_THRESHOLD:  next_read = pack_hi_lo(high_thres, 11'h000); // see RULE4
      OFS_QUEUE_FILL_COUNT:      next_read = pack_hi_lo(q_count, 11'h000); // see RULE6
      OFS_EVENT_STATUS:          next_read = {28'h000_0000, evt_status};
      OFS_EVENT_MASK:            next_read = {28'h000_0000, evt_mask};
      default:                   next_read = 32'h0000_0000;
    endcase
  end
  assign cur_value = next_read;

  // capture read data and the status image on the first edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_latch  <= 32'h0000_0000;
      status_snap <= '0;
    end else if ((bus_state == SMF_BUS_IDLE) && avs_read) begin
      read_latch  <= next_read;
      status_snap <= evt_status;
    end
  end

  // memory partition control, only the 12 defined bits store
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      partition <= PARTITION_RESET; // see RULE1
    end else if (wr_acc && avs_address == OFS_MEMORY_PARTITION_CTRL) begin
      partition <= {20'h0_0000, wr_merged[11:0]};
    end
  end
  assign data_queue_mode    = partition[DATA_MODE_LSB +: 3]; // see RULE1
  assign data_queue_size    = partition[DATA_SIZE_LSB +: 3]; // see RULE2
  assign command_store_mode = partition[CMD_MODE_LSB +: 3];  // see RULE3
  assign command_store_size = partition[CMD_SIZE_LSB +: 3];  // see RULE3

  // high threshold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_thres <= 11'h000;
    end else if (wr_acc && avs_address == OFS_DATA_QUEUE_THRESHOLD) begin
      high_thres <= wr_merged[HI_FIELD_LSB +: FIELD11_W]; // see RULE4
    end
  end

  // program descriptors, one per launchable program
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q   <= '0;
      length_q <= '0;
    end else if (wr_acc) begin
      case (avs_address)
        OFS_PROGRAM_ZERO_DESC: begin
          base_q[0]   <= wr_merged[LO_FIELD_LSB +: FIELD11_W];
          length_q[0] <= wr_merged[HI_FIELD_LSB +: FIELD11_W];
        end
        OFS_PROGRAM_ONE_DESC: begin
          base_q[1]   <= wr_merged[LO_FIELD_LSB +: FIELD11_W];
          length_q[1] <= wr_merged[HI_FIELD_LSB +: FIELD11_W];
        end
        OFS_PROGRAM_TWO_DESC: begin
          base_q[2]   <= wr_merged[LO_FIELD_LSB +: FIELD11_W];
          length_q[2] <= wr_merged[HI_FIELD_LSB +: FIELD11_W];
        end
        OFS_PROGRAM_THREE_DESC: begin
          base_q[3]   <= wr_merged[LO_FIELD_LSB +: FIELD11_W]; // see RULE5
          length_q[3] <= wr_merged[HI_FIELD_LSB +: FIELD11_W];
        end
        default: begin
        end
      endcase
    end
  end
  assign program_base   = base_q;
  assign program_length = length_q;

  // launch bits: bit 0 only sets on write, bits 3:1 follow the write,
  // the sequencer accept clears a bit unless software sets it again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger <= '0;
    end else begin
      for (int i = 0; i < TRIGGER_W; i++) begin
        if (wr_acc && avs_address == OFS_SEQUENCE_TRIGGER && avs_byteenable[0]
            && (avs_writedata[i] || i != 0)) begin
          trigger[i] <= avs_writedata[i]; // see RULE8
        end else if (launch_accept[i]) begin
          trigger[i] <= 1'b0;
        end
      end
    end
  end
  assign launch_program = trigger; // see RULE8

  // sync output bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= '0;
    end else if (wr_acc && avs_address == OFS_EXTERNAL_SYNC_OUTPUTS) begin
      sync_q <= wr_merged[SYNC_W-1:0]; // see RULE7
    end
  end
  assign sync_out = sync_q; // see RULE7

  // a queue read pops only when a word is held
  assign q_pop      = rd_acc && (avs_address == OFS_QUEUE_READ_PORT); // see RULE9
  assign empty_read = q_pop && (q_count == 11'h000);

  smf_word_queue #(
    .WIDTH (32),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .capacity    (size_words(data_queue_size)), // see RULE2
    .stream_mode (data_queue_mode == SMF_QMODE_STREAM), // see RULE1
    .push_valid  (data_push_valid),
    .push_data   (data_push_data),
    .push_ready  (data_push_ready),
    .pop         (q_pop),
    .head        (q_head),
    .count       (q_count),
    .dropped     (q_dropped)
  );

  // high level flag while the count is at or above the threshold
  assign queue_high_level = (q_count >= high_thres); // see RULE10

  // events into the sticky status
  always_comb begin
    evt                 = '0;
    evt[EVT_HIGH_LEVEL] = queue_high_level; // see RULE10
    evt[EVT_DROPPED]    = q_dropped;
    evt[EVT_LAUNCHED]   = |(trigger & launch_accept);
    evt[EVT_EMPTY_READ] = empty_read;
  end

  smf_event_irq #(
    .N (EVT_W)
  ) u_irq (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .event_in   (evt),
    .clear_en   (rd_acc && avs_address == OFS_EVENT_STATUS),
    .clear_bits (status_snap),
    .mask_we    (wr_acc && avs_address == OFS_EVENT_MASK && avs_byteenable[0]),
    .mask_wdata (avs_writedata[EVT_W-1:0]),
    .status     (evt_status),
    .mask       (evt_mask),
    .irq        (irq)
  );

endmodule
`default_nettype wire

// file: logic/smf_word_queue.sv
// data queue with flip-flop storage, fifo and stream modes and a live count
`timescale 1ns/1ps
`default_nettype none
module smf_word_queue #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [10:0]       capacity,
  input  wire logic              stream_mode,
  input  wire logic              push_valid,
  input  wire logic [WIDTH-1:0]  push_data,
  output logic                   push_ready,
  input  wire logic              pop,
  output logic [WIDTH-1:0]       head,
  output logic [10:0]            count,
  output logic                   dropped
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [10:0] DEPTH_W = 11'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage, indexed by pointer
  logic [PW-1:0]    wr_ptr;       // next slot to fill
  logic [PW-1:0]    rd_ptr;       // oldest word
  logic [10:0]      cap_eff;      // capacity bounded by physical depth
  logic             full;         // no free slot within capacity
  logic             empty;        // nothing held
  logic             do_push;      // word accepted this cycle
  logic             do_pop;       // oldest word leaves this cycle
  logic             do_drop;      // stream mode discards the oldest word

  // capacity cannot exceed the flip-flops actually built
  assign cap_eff = (capacity > DEPTH_W) ? DEPTH_W : capacity;
  assign full    = (count >= cap_eff);
  assign empty   = (count == 11'h000);
  // fifo mode stalls the source when full; stream mode keeps accepting
  assign push_ready = (cap_eff != 11'h000) && (!full || stream_mode || pop);
  assign do_push = push_valid && push_ready;
  assign do_pop  = pop && !empty;
  assign do_drop = do_push && full && stream_mode && !do_pop && !empty;
  assign head    = mem[rd_ptr];
  assign dropped = do_drop;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= PW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (do_pop || do_drop) begin
        rd_ptr <= PW'((rd_ptr + 1'b1) % DEPTH);
      end
    end
  end

  // word count follows pushes and pops (see RULE6)
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 11'h000;
    end else if (do_push && !do_pop && !do_drop) begin
      count <= count + 11'h001;
    end else if (do_pop && !do_push) begin
      count <= count - 11'h001;
    end
  end
endmodule
`default_nettype wire
